//--- shared/udma_host_pkg.sv
// package: register map, pin bundles, states and timing of the ultra dma burst host
package udma_host_pkg;
   // clock rate of clock_in in MHz
   localparam int CLK_MHZ = 100;
   // register word offsets on the avalon slave
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_MODE = 3'h1;
   localparam logic [2:0] REG_COUNT = 3'h2;
   localparam logic [2:0] REG_ADDR = 3'h3;
   localparam logic [2:0] REG_TXDATA = 3'h4;
   localparam logic [2:0] REG_RXDATA = 3'h5;
   localparam logic [2:0] REG_STATUS = 3'h6;
   localparam logic [2:0] REG_CRC = 3'h7;
   // control register bit positions
   localparam int CTRL_START = 0;
   localparam int CTRL_DIR_READ = 1;
   localparam int CTRL_SOFT_RST = 2;
   localparam int CTRL_HARD_RST = 3;
   localparam int CTRL_KEEP_MODE = 4;
   localparam int CTRL_IDE = 5;
   // mode register field positions
   localparam int MODE_SEL_LSB = 0;
   localparam int MODE_MAX_LSB = 4;
   // status register bit positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_EARLY = 2;
   localparam int STAT_REFUSED = 3;
   localparam int STAT_IRQ = 4;
   localparam int STAT_TX_FULL = 5;
   localparam int STAT_RX_AVAIL = 6;
   localparam int STAT_MODE_OK = 7;
   localparam int STAT_STATE_LSB = 8;
   // values after reset, and the crc polynomial
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [10:0] ADDR_RST = 11'h000;
   localparam logic [15:0] CRC_SEED = 16'h4ABA;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   // minimum strobe edge spacing per mode in ns, and the crc hold before dmack release
   localparam int UDMA_MODES = 7;
   localparam int CYC_NS [UDMA_MODES] = '{240, 160, 120, 90, 60, 40, 24};
   localparam int CRC_HOLD_NS = 20;
   // least times round up to whole cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc
   localparam int CRC_HOLD_CYC = ns_to_cyc(CRC_HOLD_NS);
   // burst engine states, gray along idle, request, transfer, end, home, crc, release
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT_RQ = 3'b001,
      ST_XFER = 3'b011,
      ST_TERM = 3'b010,
      ST_HOME = 3'b110,
      ST_CRC = 3'b111,
      ST_DONE = 3'b101
   } state_t;
   // levels arriving from the device pins
   typedef struct packed {
      logic dmarq;
      logic wait_line;
      logic intrq;
      logic [15:0] data;
   } dev_pins_t;
   // levels the host drives onto the device pins
   typedef struct packed {
      logic dmack_n;
      logic iowr_stop;
      logic iord_line;
      logic card_enable_low_n;
      logic card_enable_high_n;
      logic [10:0] addr;
      logic [15:0] data;
      logic data_oe_n;
   } host_pins_t;
endpackage : udma_host_pkg

//--- design/pin_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock, reset, enable
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   // first stage is read only by the second stage
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         meta_q <= '0;
         sync_out <= '0;
      end else if (ce_in) begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : pin_sync
`default_nettype wire

//--- design/burst_crc.sv
// crc accumulator over 16-bit burst words
`timescale 1ns/1ps
`default_nettype none
module burst_crc #(
   parameter logic [15:0] SEED = udma_host_pkg::CRC_SEED,
   parameter logic [15:0] POLY = udma_host_pkg::CRC_POLY
) (
   // clock, reset, enable
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // control and data
   input wire logic init_in,
   input wire logic en_in,
   input wire logic [15:0] data_in,
   output logic [15:0] crc_out
);
   logic [15:0] next_crc;
   // bitwise shift, msb of the word first
   always_comb begin
      next_crc = crc_out;
      for (int i = 15; i >= 0; i--) begin
         if (next_crc[15] ^ data_in[i]) begin
            next_crc = {next_crc[14:0], 1'b0} ^ POLY;
         end else begin
            next_crc = {next_crc[14:0], 1'b0};
         end
      end
   end
   // seed at burst start, fold one word per strobe edge
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         crc_out <= SEED;
      end else if (ce_in) begin
         if (init_in) begin
            crc_out <= SEED;
         end else if (en_in) begin
            crc_out <= next_crc;
         end
      end
   end
endmodule : burst_crc
`default_nettype wire

//--- design/udma_host.sv
// ultra dma burst host controller: avalon register slave and burst engine
`timescale 1ns/1ps
`default_nettype none
module udma_host #(
   parameter int RX_DEPTH = 4
) (
   // clock, reset, enable
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // avalon-mm slave
   input wire logic [2:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // device pins
   input wire udma_host_pkg::dev_pins_t dev_in,
   output udma_host_pkg::host_pins_t host_out
);
   localparam int PW = $clog2(RX_DEPTH);
   localparam logic [PW:0] RX_FULL = (PW + 1)'(RX_DEPTH);

   udma_host_pkg::dev_pins_t dev_s;
   udma_host_pkg::state_t state_q;
   logic wl_prev_q;
   logic dir_read_q;
   logic ide_q;
   logic keep_q;
   logic [2:0] mode_q;
   logic [2:0] max_q;
   logic mode_valid_q;
   logic [15:0] count_q;
   logic [10:0] addr_q;
   logic [15:0] tx_q;
   logic tx_full_q;
   logic loaded_q;
   logic [15:0] rx_mem_q [RX_DEPTH];
   logic [PW-1:0] rx_wp_q;
   logic [PW-1:0] rx_rp_q;
   logic [PW:0] rx_cnt_q;
   logic [7:0] timer_q;
   logic [7:0] cyc_cnt;
   logic done_q;
   logic early_q;
   logic refused_q;
   logic [15:0] crc;
   logic strobe_edge;
   logic take_rx;
   logic send_tx;
   logic ack_rd;
   logic ack_wr;
   logic pop_rx;
   logic push_tx;
   logic ctrl_wr;
   logic start_req;
   logic start_ok;
   logic burst_init;
   logic busy;
   logic clr_done;
   logic clr_early;
   logic clr_refused;
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic servable;

   // every pin level from the device crosses two flops first
   pin_sync #(
      .WIDTH($bits(udma_host_pkg::dev_pins_t))
   ) u_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .async_in(dev_in),
      .sync_out(dev_s)
   );

   // host and device crc run over the same words of each burst
   burst_crc u_crc (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .init_in(burst_init),
      .en_in(take_rx | send_tx),
      .data_in(dir_read_q ? dev_s.data : host_out.data),
      .crc_out(crc)
   );

   // strobe spacing for the selected mode
   always_comb begin
      cyc_cnt = 8'(udma_host_pkg::ns_to_cyc(udma_host_pkg::CYC_NS[mode_q]));
   end

   // bus handshake and burst events
   assign ack_rd = avs_read_in & ~avs_waitrequest_out;
   assign ack_wr = avs_write_in & ~avs_waitrequest_out;
   assign ctrl_wr = ack_wr & (avs_address_in == udma_host_pkg::REG_CTRL);
   assign push_tx = ack_wr & (avs_address_in == udma_host_pkg::REG_TXDATA);
   assign pop_rx = ack_rd & (avs_address_in == udma_host_pkg::REG_RXDATA) & (rx_cnt_q != '0);
   assign start_req = ctrl_wr & avs_writedata_in[udma_host_pkg::CTRL_START] & (state_q == udma_host_pkg::ST_IDLE);
   assign start_ok = start_req & mode_valid_q & (mode_q <= max_q) & (avs_writedata_in[31:16] != 16'h0000);
   assign busy = (state_q != udma_host_pkg::ST_IDLE);
   assign burst_init = (state_q == udma_host_pkg::ST_WAIT_RQ);
   assign strobe_edge = dev_s.wait_line ^ wl_prev_q;
   // a strobe edge after dmarq drops or stop rises carries no word
   assign take_rx = (state_q == udma_host_pkg::ST_XFER) & dir_read_q & strobe_edge & dev_s.dmarq
                    & (rx_cnt_q != RX_FULL) & (count_q != 16'h0000);
   assign send_tx = (state_q == udma_host_pkg::ST_XFER) & ~dir_read_q & loaded_q & (timer_q == 8'h00)
                    & ~dev_s.wait_line & dev_s.dmarq & (count_q != 16'h0000);
   assign clr_done = ack_wr & (avs_address_in == udma_host_pkg::REG_STATUS) & avs_writedata_in[udma_host_pkg::STAT_DONE];
   assign clr_early = ack_wr & (avs_address_in == udma_host_pkg::REG_STATUS) & avs_writedata_in[udma_host_pkg::STAT_EARLY];
   assign clr_refused = ack_wr & (avs_address_in == udma_host_pkg::REG_STATUS)
                        & avs_writedata_in[udma_host_pkg::STAT_REFUSED];

   // status word gathered for the read mux
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[udma_host_pkg::STAT_BUSY] = busy;
      status_word[udma_host_pkg::STAT_DONE] = done_q;
      status_word[udma_host_pkg::STAT_EARLY] = early_q;
      status_word[udma_host_pkg::STAT_REFUSED] = refused_q;
      status_word[udma_host_pkg::STAT_IRQ] = dev_s.intrq;
      status_word[udma_host_pkg::STAT_TX_FULL] = tx_full_q;
      status_word[udma_host_pkg::STAT_RX_AVAIL] = (rx_cnt_q != '0);
      status_word[udma_host_pkg::STAT_MODE_OK] = mode_valid_q;
      status_word[udma_host_pkg::STAT_STATE_LSB +: 3] = state_q;
   end

   // read mux and whether an access can be answered now
   always_comb begin
      rd_mux = 32'h0000_0000;
      servable = 1'b1;
      case (avs_address_in)
         udma_host_pkg::REG_CTRL: rd_mux = {26'h0, ide_q, keep_q, 2'h0, dir_read_q, 1'b0};
         udma_host_pkg::REG_MODE: rd_mux = {25'h0, max_q, 1'b0, mode_q};
         udma_host_pkg::REG_COUNT: rd_mux = {16'h0000, count_q};
         udma_host_pkg::REG_ADDR: rd_mux = {21'h0, addr_q};
         udma_host_pkg::REG_TXDATA: begin
            rd_mux = {16'h0000, tx_q};
            servable = ~(avs_write_in & tx_full_q);
         end
         udma_host_pkg::REG_RXDATA: begin
            rd_mux = (rx_cnt_q != '0) ? {16'h0000, rx_mem_q[rx_rp_q]} : 32'h0000_0000;
            servable = ~(avs_read_in & busy & dir_read_q & (rx_cnt_q == '0));
         end
         udma_host_pkg::REG_STATUS: rd_mux = status_word;
         udma_host_pkg::REG_CRC: rd_mux = {16'h0000, crc};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // avalon answer: waitrequest drops for exactly one cycle per access
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h0000_0000;
      end else if (ce_in) begin
         if (!avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b1;
         end else if ((avs_read_in | avs_write_in) && servable) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= rd_mux;
         end
      end
   end

   // configuration; writes ignored while a command runs
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         dir_read_q <= 1'b0;
         ide_q <= 1'b0;
         keep_q <= 1'b0;
         mode_q <= udma_host_pkg::MODE_RST;
         max_q <= udma_host_pkg::MODE_RST;
         mode_valid_q <= 1'b0;
         addr_q <= udma_host_pkg::ADDR_RST;
      end else if (ce_in) begin
         if (ctrl_wr && !busy) begin
            dir_read_q <= avs_writedata_in[udma_host_pkg::CTRL_DIR_READ];
            ide_q <= avs_writedata_in[udma_host_pkg::CTRL_IDE];
            keep_q <= avs_writedata_in[udma_host_pkg::CTRL_KEEP_MODE];
            if (avs_writedata_in[udma_host_pkg::CTRL_HARD_RST]) begin
               mode_valid_q <= 1'b0;
            end else if (avs_writedata_in[udma_host_pkg::CTRL_SOFT_RST] && !keep_q) begin
               mode_valid_q <= 1'b0;
            end
            // with keep set a soft reset leaves the mode standing
         end
         if (ack_wr && !busy && avs_address_in == udma_host_pkg::REG_MODE) begin
            mode_q <= avs_writedata_in[udma_host_pkg::MODE_SEL_LSB +: 3];
            max_q <= avs_writedata_in[udma_host_pkg::MODE_MAX_LSB +: 3];
            mode_valid_q <= 1'b1;
         end
         // address only changes between commands, never inside one
         if (ack_wr && !busy && avs_address_in == udma_host_pkg::REG_ADDR) begin
            addr_q <= avs_writedata_in[10:0];
         end
      end
   end

   // outgoing word: one holding register, software stalls while it is full
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         tx_q <= 16'h0000;
         tx_full_q <= 1'b0;
      end else if (ce_in) begin
         if (push_tx) begin
            tx_q <= avs_writedata_in[15:0];
            tx_full_q <= 1'b1;
         end else if (loaded_q && send_tx) begin
            tx_full_q <= 1'b0;
         end
      end
   end

   // incoming words: small store absorbs the words that follow a pause
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rx_wp_q <= '0;
         rx_rp_q <= '0;
         rx_cnt_q <= '0;
         for (int i = 0; i < RX_DEPTH; i++) begin
            rx_mem_q[i] <= 16'h0000;
         end
      end else if (ce_in) begin
         if (take_rx) begin
            rx_mem_q[rx_wp_q] <= dev_s.data;
            rx_wp_q <= rx_wp_q + 1'b1;
         end
         if (pop_rx) begin
            rx_rp_q <= rx_rp_q + 1'b1;
         end
         if (take_rx && !pop_rx) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
         end else if (pop_rx && !take_rx) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
         end
      end
   end

   // sticky flags; a new event wins over a clear in the same cycle
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         done_q <= 1'b0;
         early_q <= 1'b0;
         refused_q <= 1'b0;
      end else if (ce_in) begin
         if (state_q == udma_host_pkg::ST_DONE && (count_q == 16'h0000 || dev_s.intrq)) begin
            done_q <= 1'b1;
         end else if (clr_done) begin
            done_q <= 1'b0;
         end
         if (state_q == udma_host_pkg::ST_DONE && count_q != 16'h0000 && dev_s.intrq) begin
            early_q <= 1'b1;
         end else if (clr_early) begin
            early_q <= 1'b0;
         end
         if (start_req && !start_ok) begin
            refused_q <= 1'b1;
         end else if (clr_refused) begin
            refused_q <= 1'b0;
         end
      end
   end

   // burst engine and the pins it owns
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_q <= udma_host_pkg::ST_IDLE;
         wl_prev_q <= 1'b0;
         count_q <= udma_host_pkg::COUNT_RST;
         timer_q <= 8'h00;
         loaded_q <= 1'b0;
         host_out.dmack_n <= 1'b1;
         host_out.iowr_stop <= 1'b1;
         host_out.iord_line <= 1'b1;
         host_out.card_enable_low_n <= 1'b1;
         host_out.card_enable_high_n <= 1'b1;
         host_out.addr <= udma_host_pkg::ADDR_RST;
         host_out.data <= 16'h0000;
         host_out.data_oe_n <= 1'b1;
      end else if (ce_in) begin
         wl_prev_q <= dev_s.wait_line;
         if (timer_q != 8'h00) begin
            timer_q <= timer_q - 8'h01;
         end
         // this port makes no register or memory cycles, so enables stay negated
         host_out.card_enable_low_n <= 1'b1;
         host_out.card_enable_high_n <= 1'b1;
         host_out.addr <= ide_q ? 11'h000 : addr_q;
         case (state_q)
            udma_host_pkg::ST_IDLE: begin
               if (start_ok) begin
                  count_q <= avs_writedata_in[31:16];
                  state_q <= udma_host_pkg::ST_WAIT_RQ;
               end
            end
            udma_host_pkg::ST_WAIT_RQ: begin
               // dmack only answers a seen request
               if (dev_s.dmarq) begin
                  host_out.dmack_n <= 1'b0;
                  host_out.iowr_stop <= 1'b0;
                  host_out.iord_line <= dir_read_q ? 1'b0 : 1'b1;
                  host_out.data_oe_n <= dir_read_q;
                  loaded_q <= 1'b0;
                  timer_q <= cyc_cnt;
                  state_q <= udma_host_pkg::ST_XFER;
               end else if (dev_s.intrq) begin
                  state_q <= udma_host_pkg::ST_DONE;
               end
            end
            udma_host_pkg::ST_XFER: begin
               if (dir_read_q) begin
                  // pause by dropping ready while words wait for software
                  if (take_rx) begin
                     count_q <= count_q - 16'h0001;
                  end
                  host_out.iord_line <= (rx_cnt_q != '0) || take_rx || (count_q == 16'h0000);
                  if (!dev_s.dmarq || (count_q == 16'h0000 && rx_cnt_q == '0)) begin
                     host_out.iord_line <= 1'b1;
                     host_out.iowr_stop <= 1'b1;
                     state_q <= udma_host_pkg::ST_TERM;
                  end
               end else begin
                  if (!loaded_q && tx_full_q && count_q != 16'h0000) begin
                     host_out.data <= tx_q;
                     loaded_q <= 1'b1;
                     timer_q <= cyc_cnt;
                  end
                  if (send_tx) begin
                     host_out.iord_line <= ~host_out.iord_line;
                     loaded_q <= 1'b0;
                     count_q <= count_q - 16'h0001;
                  end else if (!dev_s.dmarq || count_q == 16'h0000) begin
                     host_out.iowr_stop <= 1'b1;
                     state_q <= udma_host_pkg::ST_TERM;
                  end
               end
            end
            udma_host_pkg::ST_TERM: begin
               // stop is up; wait for the device to take dmarq away
               if (!dev_s.dmarq) begin
                  state_q <= udma_host_pkg::ST_HOME;
               end
            end
            udma_host_pkg::ST_HOME: begin
               // strobe back to its asserted level, no word on this edge
               host_out.iord_line <= 1'b1;
               host_out.data <= crc;
               host_out.data_oe_n <= 1'b0;
               timer_q <= 8'(udma_host_pkg::CRC_HOLD_CYC);
               state_q <= udma_host_pkg::ST_CRC;
            end
            udma_host_pkg::ST_CRC: begin
               if (timer_q == 8'h00) begin
                  host_out.dmack_n <= 1'b1;
                  state_q <= udma_host_pkg::ST_DONE;
               end
            end
            udma_host_pkg::ST_DONE: begin
               // crc held through the dmack edge, bus released one cycle later
               host_out.data_oe_n <= 1'b1;
               host_out.iowr_stop <= 1'b1;
               host_out.iord_line <= 1'b1;
               if (count_q == 16'h0000 || dev_s.intrq) begin
                  state_q <= udma_host_pkg::ST_IDLE;
               end else begin
                  state_q <= udma_host_pkg::ST_WAIT_RQ;
               end
            end
            default: state_q <= udma_host_pkg::ST_IDLE;
         endcase
      end
   end
endmodule : udma_host
`default_nettype wire

//--- testbench/udma_host_monitor.sv
// checker: burst pin relations at the host controller ports
`timescale 1ns/1ps
`default_nettype none
module udma_host_monitor (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // device pins
   input wire udma_host_pkg::dev_pins_t dev_in,
   input wire udma_host_pkg::host_pins_t host_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // crc word held on the bus across the acknowledge release
   sequence crc_on_bus;
      !host_out.data_oe_n && $past(!host_out.data_oe_n);
   endsequence
   sequence lines_home;
      host_out.iowr_stop && host_out.iord_line;
   endsequence
   AST_CE_NEGATED: assert property (!host_out.dmack_n |-> host_out.card_enable_low_n && host_out.card_enable_high_n)
      else $error("card enable active in burst");
   AST_ADDR_FIXED: assert property (!host_out.dmack_n && $past(!host_out.dmack_n) |-> $stable(host_out.addr))
      else $error("address moved in burst");
   AST_ACK_AFTER_REQ: assert property ($fell(host_out.dmack_n) |-> $past(dev_in.dmarq, 3))
      else $error("acknowledge without request");
   AST_OWNER_SPLIT: assert property ($fell(host_out.dmack_n) |-> host_out.data_oe_n != host_out.iord_line)
      else $error("wrong line roles at burst start");
   AST_READ_RELEASED: assert property (!host_out.dmack_n && $past(!host_out.dmack_n) && !host_out.iowr_stop
      && $past(host_out.data_oe_n) |-> host_out.data_oe_n)
      else $error("host drove data in read burst");
   AST_DATA_BEFORE_STROBE: assert property (!host_out.data_oe_n && !host_out.iowr_stop
      && $changed(host_out.iord_line) |-> $stable(host_out.data))
      else $error("data moved with strobe edge");
   AST_CRC_TAIL: assert property ($rose(host_out.dmack_n) |-> crc_on_bus ##1 host_out.data_oe_n)
      else $error("crc not held at burst end");
   AST_IDLE_LINES: assert property (host_out.dmack_n && $past(host_out.dmack_n) |-> lines_home)
      else $error("lines not home outside burst");
endmodule : udma_host_monitor
bind udma_host udma_host_monitor u_udma_host_monitor (.clock_in(clock_in), .rst_in(rst_in), .dev_in(dev_in),
   .host_out(host_out));
`default_nettype wire

//--- testbench/udma_dev_model.sv
// device model: raises requests, sends read words, collects write words
`timescale 1ns/1ps
`default_nettype none
module udma_dev_model (
   // bench request and host pins
   input wire logic go_in,
   input wire udma_host_pkg::host_pins_t host_in,
   // device pins and collected words
   output udma_host_pkg::dev_pins_t dev_out,
   output logic [15:0] seen_out [0:7],
   output logic [15:0] crc_word_out,
   output int n_seen_out
);
   logic dmarq = 1'b0;
   logic strobe = 1'b1;
   logic [15:0] drv = 16'h0000;
   int k = 0;
   initial n_seen_out = 0;
   // data wire: host wins only while its enable is low
   assign dev_out.data = host_in.data_oe_n ? drv : host_in.data;
   assign dev_out.dmarq = dmarq;
   assign dev_out.intrq = 1'b0;
   // device ready low in write bursts, else the wait line is our strobe
   assign dev_out.wait_line = (!host_in.dmack_n && !host_in.data_oe_n) ? 1'b0 : strobe;
   // request stays up until the host asks to stop
   always @(posedge go_in) dmarq = 1'b1;
   always @(posedge host_in.iowr_stop) if (!host_in.dmack_n) dmarq = 1'b0;
   // either host strobe edge latches one full word
   always @(host_in.iord_line) begin
      #1;
      if (!host_in.dmack_n && !host_in.iowr_stop && !host_in.data_oe_n && n_seen_out < 8) begin
         seen_out[n_seen_out] = host_in.data;
         n_seen_out++;
      end
   end
   always @(posedge host_in.dmack_n) crc_word_out = host_in.data;
   // word first, strobe half a slot later; idle data keeps changing
   always begin
      #62.5;
      if (dmarq && !host_in.dmack_n && host_in.data_oe_n && !host_in.iowr_stop && !host_in.iord_line) begin
         drv = 16'(32'hC000 + k);
         #31;
         strobe = ~strobe;
         k++;
      end else
         drv = ~drv;
   end
endmodule : udma_dev_model
`default_nettype wire

//--- testbench/udma_burst_signal_remap_bench.sv
// bench: register-driven write and read bursts against the device model
`timescale 1ns/1ps
`default_nettype none
module udma_burst_signal_remap_bench;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic go = 1'b0;
   logic [2:0] adr = 3'h0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata, q;
   logic wreq;
   logic [15:0] crc, crc_word;
   logic [15:0] seen [0:7];
   int n_seen;
   int n_fail = 0;
   int checks_done = 0;
   udma_host_pkg::dev_pins_t dev;
   udma_host_pkg::host_pins_t pins;
   always #5 clock_in = ~clock_in;
   udma_host u_udma_host (.clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .dev_in(dev), .host_out(pins));
   udma_dev_model u_udma_dev_model (.go_in(go), .host_in(pins), .dev_out(dev), .seen_out(seen),
      .crc_word_out(crc_word), .n_seen_out(n_seen));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= ~w;
      @(posedge clock_in);
      while (wreq !== 1'b0) @(posedge clock_in);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clock_in);
   endtask : bus
   task automatic rdc(input string w, input logic [2:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(w, e, q & m);
   endtask : rdc
   // poll for done, then clear it; a bounded poll
   task automatic wait_done;
      int t;
      t = 0;
      q = 32'h0;
      while (q[1] !== 1'b1 && t < 300) begin
         bus(1'b0, udma_host_pkg::REG_STATUS, 32'h0);
         t++;
      end
      chk("done", 32'h1, {31'h0, q[1]});
      bus(1'b1, udma_host_pkg::REG_STATUS, 32'h2);
      go <= 1'b0;
   endtask : wait_done
   function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [15:0] w);
      for (int i = 15; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? udma_host_pkg::CRC_POLY : 16'h0000);
      return c;
   endfunction : crc_next
   initial begin
      repeat (16) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      rdc("status", udma_host_pkg::REG_STATUS, 32'hFF, 32'h0);
      bus(1'b1, udma_host_pkg::REG_MODE, 32'h23);
      bus(1'b1, udma_host_pkg::REG_CTRL, 32'h0004_0001);
      rdc("refused", udma_host_pkg::REG_STATUS, 32'h8, 32'h8);
      bus(1'b1, udma_host_pkg::REG_STATUS, 32'h8);
      bus(1'b1, udma_host_pkg::REG_MODE, 32'h60);
      rdc("mode", udma_host_pkg::REG_MODE, 32'h77, 32'h60);
      bus(1'b1, udma_host_pkg::REG_ADDR, 32'h5A5);
      // write burst of four words; later words stall until sent
      crc = udma_host_pkg::CRC_SEED;
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, udma_host_pkg::REG_TXDATA, 32'h5AC3 + i * 32'h1010);
         crc = crc_next(crc, 16'(32'h5AC3 + i * 32'h1010));
         if (i == 0) bus(1'b1, udma_host_pkg::REG_CTRL, 32'h0004_0001);
         go <= 1'b1;
      end
      chk("addr", 32'h5A5, {21'h0, pins.addr});
      wait_done();
      chk("words", 32'd4, n_seen);
      for (int i = 0; i < 4; i++)
         chk("tx word", 32'h5AC3 + i * 32'h1010, {16'h0, seen[i]});
      chk("tx crc", {16'h0, crc}, {16'h0, crc_word});
      // read burst in fixed-drive mode
      bus(1'b1, udma_host_pkg::REG_CTRL, 32'h0004_0023);
      rdc("ctrl", udma_host_pkg::REG_CTRL, 32'h3F, 32'h22);
      go <= 1'b1;
      crc = udma_host_pkg::CRC_SEED;
      for (int i = 0; i < 4; i++) begin
         rdc("rx word", udma_host_pkg::REG_RXDATA, 32'hFFFF_FFFF, 32'hC000 + i);
         crc = crc_next(crc, 16'(32'hC000 + i));
      end
      chk("ide addr", 32'h0, {21'h0, pins.addr});
      wait_done();
      chk("rx crc", {16'h0, crc}, {16'h0, crc_word});
      bus(1'b1, udma_host_pkg::REG_CTRL, 32'h10);
      bus(1'b1, udma_host_pkg::REG_CTRL, 32'h14);
      rdc("kept mode", udma_host_pkg::REG_STATUS, 32'h80, 32'h80);
      bus(1'b1, udma_host_pkg::REG_CTRL, 32'h08);
      rdc("mode cleared", udma_host_pkg::REG_STATUS, 32'h80, 32'h0);
      bus(1'b1, udma_host_pkg::REG_MODE, 32'h60);
      bus(1'b1, udma_host_pkg::REG_CTRL, 32'h04);
      rdc("mode reverted", udma_host_pkg::REG_STATUS, 32'h80, 32'h0);
      print_verdict();
   end
   // watchdog well past the expected run length
   initial begin
      #400000;
      n_fail++;
      print_verdict();
   end
endmodule : udma_burst_signal_remap_bench
`default_nettype wire
